// >>> hw/cdi_pkg.sv
// constants and carrier types for the character display instruction core
package cdi_pkg;

    // cursor address counter limits
    localparam logic [6:0] CDI_AC_RESET    = 7'h00;
    localparam logic [6:0] CDI_DDR_L0_LAST = 7'h27;
    localparam logic [6:0] CDI_DDR_L1_BASE = 7'h40;
    localparam logic [6:0] CDI_DDR_L1_LAST = 7'h67;
    localparam logic [5:0] CDI_CG_LAST     = 6'h3F;
    localparam logic [5:0] CDI_CG_FIRST    = 6'h00;

    // display char ram and glyph ram geometry
    localparam logic [5:0] CDI_LINE_LEN    = 6'h28;
    localparam logic [5:0] CDI_LINE_LAST   = 6'h27;
    localparam logic [5:0] CDI_ROW_LEN     = 6'h14;
    localparam int         CDI_DDR_DEPTH   = 80;
    localparam int         CDI_CG_DEPTH    = 64;

    // values after reset or clear, and the byte read from an off-line address
    localparam logic [7:0] CDI_SPACE       = 8'h20;
    localparam logic [7:0] CDI_CG_RESET    = 8'h00;
    localparam logic [7:0] CDI_BAD_READ    = 8'h00;
    localparam logic [5:0] CDI_SHIFT_RESET = 6'h00;
    localparam logic       CDI_INC_RESET   = 1'b1;
    localparam logic       CDI_SHIFT_EN_RESET = 1'b0;
    localparam logic       CDI_DISP_RESET  = 1'b0;

    // instruction field positions
    localparam int CDI_ENTRY_INC_BIT   = 1;
    localparam int CDI_ENTRY_SHIFT_BIT = 0;
    localparam int CDI_ONOFF_DISP_BIT  = 2;
    localparam int CDI_ONOFF_CUR_BIT   = 1;
    localparam int CDI_ONOFF_BLINK_BIT = 0;

    // one transfer from the interface front end
    typedef struct packed {
        logic       rs;
        logic       rw;
        logic [7:0] data;
    } cdi_xfer_t;

    // entry mode and display control bits
    typedef struct packed {
        logic inc;
        logic shift_en;
        logic disp_on;
        logic cursor_on;
        logic blink_on;
    } cdi_mode_t;

endpackage

// >>> hw/cdi_core.sv
// instruction core: address counter, display char ram, glyph pattern ram
`timescale 1ns/1ps
`default_nettype none

//
// Summary of operation
// - increment steps 27H to 40H, 67H to 00H
// - decrement steps 40H to 27H, 00H to 67H
// - glyph ram access wraps counter within 00H-3FH
// - display counter value is the cursor position
// - display ram at 00-27H, 40-67H, all usable
// - unshifted rows show 00, 40, 14, 54 onward
// - left shift advances address, circular per line
// - right shift lowers address, circular per line
// - glyph ram 00-3FH holds eight 5x8 glyphs
// - codes 00-0FH map to glyph rows, bit3 ignored
// - clear fills spaces, homes, unshifts, sets increment
// - home zeroes counter and shift, rams untouched
// - entry mode stores direction and shift bits
// - shift only after display ram write
// - entry mode leaves rams and counter alone
// - register select high routes byte to ram
// - address set selects ram and loads counter
// - instruction read returns zero flag and counter
// - ram access uses counter then steps; display writes shift if enabled
// - reset: spaces, home, unshifted, inc, all off
module cdi_core
    import cdi_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       xfer_valid,
    input  wire cdi_xfer_t  xfer,
    input  wire logic [1:0] scan_row,
    input  wire logic [4:0] scan_col,
    input  wire logic [7:0] glyph_code,
    input  wire logic [2:0] glyph_line,
    output logic            rd_valid_r,
    output logic [7:0]      rd_data_r,
    output logic [6:0]      cursor_address_counter,
    output logic            sel_glyph_r,
    output logic [5:0]      shift_r,
    output cdi_mode_t       mode_r,
    output logic [7:0]      scan_code_r,
    output logic [4:0]      glyph_pixels_r,
    output logic            glyph_hit_r
);

    // display address after one step
    function automatic logic [6:0] ddr_step(input logic [6:0] a, input logic inc);
        logic [6:0] r;
        r = a;
        if (inc)
        begin
            if (a == CDI_DDR_L0_LAST)
                r = CDI_DDR_L1_BASE;
            else if (a == CDI_DDR_L1_LAST)
                r = CDI_AC_RESET;
            else
                r = a + 7'h01;
        end
        else
        begin
            if (a == CDI_DDR_L1_BASE)
                r = CDI_DDR_L0_LAST;
            else if (a == CDI_AC_RESET)
                r = CDI_DDR_L1_LAST;
            else
                r = a - 7'h01;
        end
        return r;
    endfunction

    // glyph address after one step
    function automatic logic [5:0] cg_step(input logic [5:0] a, input logic inc);
        logic [5:0] r;
        r = a;
        if (inc)
            r = (a == CDI_CG_LAST) ? CDI_CG_FIRST : a + 6'h01;
        else
            r = (a == CDI_CG_FIRST) ? CDI_CG_LAST : a - 6'h01;
        return r;
    endfunction

    // position within a circular line, one step either way
    function automatic logic [5:0] pos_step(input logic [5:0] p, input logic up);
        logic [5:0] r;
        r = p;
        if (up)
            r = (p == CDI_LINE_LAST) ? 6'h00 : p + 6'h01;
        else
            r = (p == 6'h00) ? CDI_LINE_LAST : p - 6'h01;
        return r;
    endfunction

    // display address to storage index; valid only inside the two lines
    function automatic logic [7:0] ddr_index(input logic [6:0] a);
        logic [7:0] r;
        r = {1'b0, (a[6] ? 7'h28 : 7'h00) + {1'b0, a[5:0]}};
        if (a[5:0] > CDI_LINE_LAST)
            r = 8'hFF;
        return r;
    endfunction

    // position plus shift, folded back into one circular line
    function automatic logic [5:0] line_fold(input logic [5:0] p, input logic [5:0] s);
        logic [6:0] sum;
        sum = {1'b0, p} + {1'b0, s};
        if (sum >= {1'b0, CDI_LINE_LEN})
            sum = sum - {1'b0, CDI_LINE_LEN};
        return sum[5:0];
    endfunction

    // screen row and column to position within its circular line
    function automatic logic [5:0] row_pos(input logic [1:0] row, input logic [4:0] col);
        return {1'b0, col} + (row[1] ? CDI_ROW_LEN : 6'h00);
    endfunction

    // codes that select a user glyph, bit 3 ignored
    function automatic logic user_glyph(input logic [7:0] code);
        return (code[7:4] == 4'h0);
    endfunction

    // glyph ram address of one pixel row of a user glyph
    function automatic logic [5:0] glyph_row_addr(input logic [7:0] code, input logic [2:0] row);
        return {code[2:0], row};
    endfunction

    logic [7:0] ddr_mem [CDI_DDR_DEPTH];
    logic [7:0] cg_mem  [CDI_CG_DEPTH];

    // display ram read; off-line addresses give the fallback byte
    function automatic logic [7:0] ddr_fetch(input logic [7:0] idx, input logic [7:0] dflt);
        logic [7:0] r;
        r = dflt;
        if (idx != 8'hFF)
            r = ddr_mem[idx[6:0]];
        return r;
    endfunction

    // transfer decode; don't-care bits never reach the compare
    logic       ins_wr;
    logic       ins_rd;
    logic       dat_wr;
    logic       dat_rd;
    logic       is_clear;
    logic       is_home;
    logic       is_entry;
    logic       is_onoff;
    logic       is_cgset;
    logic       is_ddset;
    logic [7:0] ac_idx;
    logic       ac_ok;
    logic       ram_acc;
    logic       ddr_wr;
    logic       cg_wr;

    assign ins_wr   = xfer_valid && !xfer.rs && !xfer.rw;
    assign ins_rd   = xfer_valid && !xfer.rs &&  xfer.rw;
    assign dat_wr   = xfer_valid &&  xfer.rs && !xfer.rw;
    assign dat_rd   = xfer_valid &&  xfer.rs &&  xfer.rw;
    assign is_clear = ins_wr && (xfer.data == 8'h01);
    assign is_home  = ins_wr && (xfer.data[7:1] == 7'h01);
    assign is_entry = ins_wr && (xfer.data[7:2] == 6'h01);
    assign is_onoff = ins_wr && (xfer.data[7:3] == 5'h01);
    assign is_cgset = ins_wr && (xfer.data[7:6] == 2'h1);
    assign is_ddset = ins_wr &&  xfer.data[7];
    assign ac_idx   = ddr_index(cursor_address_counter);
    assign ac_ok    = (ac_idx != 8'hFF);
    assign ram_acc  = dat_wr || dat_rd;
    assign ddr_wr   = dat_wr && !sel_glyph_r;
    assign cg_wr    = dat_wr &&  sel_glyph_r;

    // cursor address counter and ram select
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cursor_address_counter <= CDI_AC_RESET;
            sel_glyph_r            <= 1'b0;
        end
        else if (is_clear || is_home)
        begin
            cursor_address_counter <= CDI_AC_RESET;
            sel_glyph_r            <= 1'b0;
        end
        else if (is_ddset)
        begin
            cursor_address_counter <= xfer.data[6:0];
            sel_glyph_r            <= 1'b0;
        end
        else if (is_cgset)
        begin
            cursor_address_counter <= {1'b0, xfer.data[5:0]};
            sel_glyph_r            <= 1'b1;
        end
        else if (ram_acc)
        begin
            if (sel_glyph_r)
                cursor_address_counter <=
                    {1'b0, cg_step(cursor_address_counter[5:0], mode_r.inc)};
            else
                cursor_address_counter <=
                    ddr_step(cursor_address_counter, mode_r.inc);
        end
    end

    // entry mode and display control bits
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mode_r.inc       <= CDI_INC_RESET;
            mode_r.shift_en  <= CDI_SHIFT_EN_RESET;
            mode_r.disp_on   <= CDI_DISP_RESET;
            mode_r.cursor_on <= CDI_DISP_RESET;
            mode_r.blink_on  <= CDI_DISP_RESET;
        end
        else if (is_clear)
        begin
            mode_r.inc <= 1'b1;
        end
        else if (is_entry)
        begin
            mode_r.inc      <= xfer.data[CDI_ENTRY_INC_BIT];
            mode_r.shift_en <= xfer.data[CDI_ENTRY_SHIFT_BIT];
        end
        else if (is_onoff)
        begin
            mode_r.disp_on   <= xfer.data[CDI_ONOFF_DISP_BIT];
            mode_r.cursor_on <= xfer.data[CDI_ONOFF_CUR_BIT];
            mode_r.blink_on  <= xfer.data[CDI_ONOFF_BLINK_BIT];
        end
    end

    // display shift offset, 0..39 positions to the left
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            shift_r <= CDI_SHIFT_RESET;
        else if (is_clear || is_home)
            shift_r <= CDI_SHIFT_RESET;
        else if (ddr_wr && mode_r.shift_en)
            shift_r <= pos_step(shift_r, mode_r.inc);
    end

    // display char ram
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < CDI_DDR_DEPTH; i++)
                ddr_mem[i] <= CDI_SPACE;
        end
        else if (is_clear)
        begin
            for (int i = 0; i < CDI_DDR_DEPTH; i++)
                ddr_mem[i] <= CDI_SPACE;
        end
        else if (ddr_wr && ac_ok)
        begin
            ddr_mem[ac_idx[6:0]] <= xfer.data;
        end
    end

    // glyph pattern ram, untouched by clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < CDI_CG_DEPTH; i++)
                cg_mem[i] <= CDI_CG_RESET;
        end
        else if (cg_wr)
        begin
            cg_mem[cursor_address_counter[5:0]] <= xfer.data;
        end
    end

    // read strobe, one cycle after the transfer
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rd_valid_r <= 1'b0;
        else
            rd_valid_r <= ins_rd || dat_rd;
    end

    // read answer, held until the next read
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rd_data_r <= 8'h00;
        else if (ins_rd)
            rd_data_r <= {1'b0, cursor_address_counter};
        else if (dat_rd && sel_glyph_r)
            rd_data_r <= cg_mem[cursor_address_counter[5:0]];
        else if (dat_rd)
            rd_data_r <= ddr_fetch(ac_idx, CDI_BAD_READ);
    end

    // screen position to display address
    logic       scan_line1;
    logic [5:0] scan_pos;
    logic [5:0] scan_lpos;
    logic [6:0] scan_addr;
    logic [7:0] scan_idx;

    assign scan_line1 = scan_row[0];
    assign scan_pos   = row_pos(scan_row, scan_col);
    assign scan_lpos  = line_fold(scan_pos, shift_r);
    assign scan_addr  = (scan_line1 ? CDI_DDR_L1_BASE : 7'h00) + {1'b0, scan_lpos};
    assign scan_idx   = ddr_index(scan_addr);

    // character under scan
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            scan_code_r <= CDI_SPACE;
        else
            scan_code_r <= ddr_fetch(scan_idx, CDI_SPACE);
    end

    // glyph pixel row for the code being drawn
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            glyph_pixels_r <= 5'h00;
            glyph_hit_r    <= 1'b0;
        end
        else
        begin
            glyph_hit_r    <= user_glyph(glyph_code);
            glyph_pixels_r <= user_glyph(glyph_code)
                            ? cg_mem[glyph_row_addr(glyph_code, glyph_line)][4:0]
                            : 5'h00;
        end
    end

endmodule

`default_nettype wire

// >>> test/cdi_core_assertions.sv
// checker watching the instruction core ports
`timescale 1ns/1ps
`default_nettype none
module cdi_chk
    import cdi_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       xfer_valid,
    input wire cdi_xfer_t  xfer,
    input wire logic       rd_valid_r,
    input wire logic [7:0] rd_data_r,
    input wire logic [6:0] cursor_address_counter,
    input wire logic       sel_glyph_r,
    input wire logic [5:0] shift_r,
    input wire cdi_mode_t  mode_r
);
    logic [6:0] ac;
    logic       ins;
    logic       dw;
    assign ac  = cursor_address_counter;
    assign ins = xfer_valid && !xfer.rs && !xfer.rw;
    assign dw  = xfer_valid && xfer.rs && !sel_glyph_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_rd; xfer_valid && xfer.rw |=> rd_valid_r; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_quiet; !(xfer_valid && xfer.rw) |=> !rd_valid_r; endproperty
    a_quiet: assert property (p_quiet) else $error("stray read pulse");
    property p_acrd;
        xfer_valid && !xfer.rs && xfer.rw |=> rd_data_r == {1'b0, $past(ac)} && $stable(ac);
    endproperty
    a_acrd: assert property (p_acrd) else $error("counter read wrong");
    property p_inc; dw && mode_r.inc && ac == 7'h27 |=> ac == 7'h40; endproperty
    a_inc: assert property (p_inc) else $error("increment wrap wrong");
    property p_dec; dw && !mode_r.inc && ac == 7'h00 |=> ac == 7'h67; endproperty
    a_dec: assert property (p_dec) else $error("decrement wrap wrong");
    property p_cg;
        xfer_valid && xfer.rs && sel_glyph_r && !mode_r.inc && ac == 7'h00 |=> ac == 7'h3F;
    endproperty
    a_cg: assert property (p_cg) else $error("glyph wrap wrong");
    property p_home;
        ins && xfer.data[7:2] == 6'h00 && xfer.data[1:0] != 2'b00
            |=> ac == 7'h00 && shift_r == 6'h00;
    endproperty
    a_home: assert property (p_home) else $error("home not done");
    property p_entry;
        ins && xfer.data[7:2] == 6'h01 |=> $stable(ac) && mode_r.inc == $past(xfer.data[1]);
    endproperty
    a_entry: assert property (p_entry) else $error("entry mode wrong");
    property p_noshift;
        xfer_valid && xfer.rs && (xfer.rw || sel_glyph_r) |=> $stable(shift_r);
    endproperty
    a_noshift: assert property (p_noshift) else $error("shift on read");
    property p_addr; ins && xfer.data[7] |=> ac == $past(xfer.data[6:0]) && !sel_glyph_r;
    endproperty
    a_addr: assert property (p_addr) else $error("address set wrong");
    c_shift: cover property (dw && mode_r.shift_en);
    c_glyph: cover property (xfer_valid && xfer.rs && sel_glyph_r);
    c_read: cover property (rd_valid_r);
endmodule
`default_nettype wire

// >>> test/cdi_host.sv
// host model issuing transfers to the core
`timescale 1ns/1ps
`default_nettype none
module cdi_host
    import cdi_pkg::*;
(
    input  wire logic mclk,
    output logic      xfer_valid,
    output cdi_xfer_t xfer
);
    initial
    begin
        xfer_valid = 1'b0;
        xfer       = '0;
    end
    // rs high marks ram data, rw high a read
    task automatic send(input logic rs, input logic rw, input logic [7:0] d);
        @(posedge mclk);
        xfer_valid <= 1'b1;
        xfer       <= {rs, rw, d};
        @(posedge mclk);
        xfer_valid <= 1'b0;
        xfer       <= ~{rs, rw, d};
    endtask
endmodule
`default_nettype wire

// >>> test/test_char_display_instruction_core.sv
// testbench for the character display instruction core
`timescale 1ns/1ps
`default_nettype none
module test_char_display_instruction_core;
    import cdi_pkg::*;
    logic       mclk, rst, xfer_valid, rd_valid_r, sel_glyph_r, glyph_hit_r;
    cdi_xfer_t  xfer;
    cdi_mode_t  mode_r;
    logic [1:0] scan_row;
    logic [4:0] scan_col, glyph_pixels_r;
    logic [7:0] glyph_code, rd_data_r, scan_code_r;
    logic [2:0] glyph_line;
    logic [6:0] ac;
    logic [5:0] shift_r;
    int         n_errors = 0, n_tests = 0, cyc = 0;

    cdi_host host (.mclk(mclk), .xfer_valid(xfer_valid), .xfer(xfer));
    cdi_core uut (.mclk(mclk), .rst(rst), .xfer_valid(xfer_valid), .xfer(xfer),
        .scan_row(scan_row), .scan_col(scan_col), .glyph_code(glyph_code),
        .glyph_line(glyph_line), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
        .cursor_address_counter(ac), .sel_glyph_r(sel_glyph_r), .shift_r(shift_r),
        .mode_r(mode_r), .scan_code_r(scan_code_r), .glyph_pixels_r(glyph_pixels_r),
        .glyph_hit_r(glyph_hit_r));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // write transfer, then counter value
    task automatic put(input logic rs, input logic [7:0] d, input logic [7:0] eac);
        host.send(rs, 1'b0, d);
        #1;
        check({1'b0, ac}, eac);
    endtask
    task automatic rd(input logic rs, input logic [7:0] exp);
        host.send(rs, 1'b1, 8'h00);
        #1;
        check({7'h00, rd_valid_r}, 8'h01);
        check(rd_data_r, exp);
    endtask
    task automatic look(input logic [1:0] r, input logic [4:0] c, input logic [7:0] exp);
        @(posedge mclk);
        scan_row <= r;
        scan_col <= c;
        @(posedge mclk);
        #1;
        check(scan_code_r, exp);
    endtask
    task automatic finish_test();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            n_errors++;
            finish_test();
        end
    end

    initial
    begin
        rst = 1'b1;
        scan_row = 2'h0;
        scan_col = 5'h00;
        glyph_code = 8'h0F;
        glyph_line = 3'h7;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        #1;
        check({1'b0, ac}, 8'h00);
        check({3'h0, mode_r}, 8'h10);
        check({2'h0, shift_r}, 8'h00);
        rd(1'b1, 8'h20);
        put(1'b0, 8'h81, 8'h01);
        put(1'b1, 8'h55, 8'h02);
        put(1'b0, 8'hA7, 8'h27);
        put(1'b1, 8'h41, 8'h40);
        put(1'b1, 8'h43, 8'h41);
        rd(1'b0, 8'h41);
        put(1'b0, 8'hE7, 8'h67);
        put(1'b1, 8'h44, 8'h00);
        look(2'h0, 5'h01, 8'h55);
        look(2'h1, 5'h00, 8'h43);
        look(2'h3, 5'h13, 8'h44);
        look(2'h2, 5'h13, 8'h41);
        put(1'b0, 8'h04, 8'h00);
        put(1'b1, 8'h30, 8'h67);
        put(1'b0, 8'hC0, 8'h40);
        put(1'b1, 8'h43, 8'h27);
        put(1'b0, 8'h06, 8'h27);
        put(1'b0, 8'h7F, 8'h3F);
        check({7'h00, sel_glyph_r}, 8'h01);
        put(1'b1, 8'h1F, 8'h00);
        @(posedge mclk);
        #1;
        check({3'h0, glyph_pixels_r}, 8'h1F);
        check({7'h00, glyph_hit_r}, 8'h01);
        @(posedge mclk);
        glyph_code <= 8'h17;
        @(posedge mclk);
        #1;
        check({7'h00, glyph_hit_r}, 8'h00);
        check({3'h0, glyph_pixels_r}, 8'h00);
        @(posedge mclk);
        glyph_code <= 8'h07;
        @(posedge mclk);
        #1;
        check({3'h0, glyph_pixels_r}, 8'h1F);
        put(1'b0, 8'h04, 8'h00);
        put(1'b1, 8'h0A, 8'h3F);
        rd(1'b1, 8'h1F);
        put(1'b0, 8'h07, 8'h3E);
        put(1'b0, 8'h80, 8'h00);
        put(1'b1, 8'h30, 8'h01);
        check({2'h0, shift_r}, 8'h01);
        look(2'h0, 5'h00, 8'h55);
        look(2'h2, 5'h13, 8'h30);
        rd(1'b1, 8'h55);
        check({2'h0, shift_r}, 8'h01);
        put(1'b0, 8'h05, 8'h02);
        put(1'b0, 8'h81, 8'h01);
        put(1'b1, 8'h55, 8'h00);
        put(1'b1, 8'h30, 8'h67);
        look(2'h0, 5'h00, 8'h41);
        look(2'h1, 5'h00, 8'h44);
        look(2'h2, 5'h05, 8'h20);
        put(1'b0, 8'h03, 8'h00);
        check({2'h0, shift_r}, 8'h00);
        look(2'h0, 5'h00, 8'h30);
        put(1'b0, 8'h01, 8'h00);
        check({7'h00, mode_r.inc}, 8'h01);
        rd(1'b1, 8'h20);
        put(1'b0, 8'h40, 8'h00);
        rd(1'b1, 8'h0A);
        put(1'b0, 8'h0E, 8'h01);
        check({3'h0, mode_r}, 8'h1E);
        put(1'b0, 8'h81, 8'h01);
        put(1'b1, 8'h66, 8'h02);
        check({2'h0, shift_r}, 8'h01);
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        #1;
        check({1'b0, ac}, 8'h00);
        check({3'h0, mode_r}, 8'h10);
        check({2'h0, shift_r}, 8'h00);
        put(1'b0, 8'h81, 8'h01);
        rd(1'b1, 8'h20);
        finish_test();
    end
endmodule
bind cdi_core cdi_chk chk (.mclk(mclk), .rst(rst), .xfer_valid(xfer_valid), .xfer(xfer),
    .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
    .cursor_address_counter(cursor_address_counter), .sel_glyph_r(sel_glyph_r),
    .shift_r(shift_r), .mode_r(mode_r));
`default_nettype wire
